// File: pmds_pkg.sv
// Package for the page mode DRAM sequencer: states, timing and field layout.
// Assumes a single 100 MHz system clock and synchronous active-high reset.
package pmds_pkg;
    localparam int      CLK_PERIOD_NS   = 10;
    localparam int      ADDR_W          = 24;
    localparam int      DATA_W          = 32;
    localparam int      BANKS           = 4;
    localparam int      SPACE_BIT       = 22;
    localparam int      BANK_HI         = 21;
    localparam int      BANK_LO         = 20;
    localparam int      ROW_LO          = 10;
    localparam int      MUX_W           = 10;
    // Cycle counts of each access, measured in controller edges
    localparam int      READ_CYCLES     = 5;
    localparam int      BLOCK_CYCLES    = 11;
    localparam int      WRITE_CYCLES    = 4;
    localparam int      PAGE_CYCLES     = 3;
    localparam int      PRECHARGE_CYC   = 2;
    localparam int      BLOCK_WORDS     = 4;
    localparam int      WORD_SPACING    = 2;
    localparam logic [3:0] CNT_ZERO     = 4'h0;
    localparam logic [3:0] CNT_ONE      = 4'h1;
    // Count at which a single read issues column, strobe and acknowledge
    localparam logic [3:0] READ_CAS_CNT = 4'h2;
    localparam logic [3:0] READ_END_CNT = 4'h3;
    localparam logic [3:0] WR_CAS_CNT   = 4'h2;
    localparam logic [3:0] PG_CAS_CNT   = 4'h1;
    localparam logic [3:0] PRE_END_CNT  = 4'h1;
    localparam logic [3:0] BLK_ACK_CNT  = 4'h5;
    localparam logic [3:0] BLK_END_CNT  = 4'h9;

    typedef enum logic [3:0] {
        PMDS_IDLE,
        PMDS_ROW_HELD,
        PMDS_PRECHARGE,
        PMDS_WRITE,
        PMDS_PAGE_WRITE,
        PMDS_READ,
        PMDS_BLOCK
    } pmds_state_type;

    typedef enum logic [1:0] {
        PMDS_PEND_WRITE,
        PMDS_PEND_READ,
        PMDS_PEND_BLOCK
    } pmds_pend_type;
endpackage

// File: pmds_word_if.sv
// Word path carrier between the sequencer and its two-entry buffer.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface pmds_word_if;
    import pmds_pkg::*;
    logic [DATA_W-1:0] data;
    logic              valid;
    logic              ready;
    modport source (output data, output valid, input ready);
    modport sink   (input data, input valid, output ready);
endinterface

// File: pmds_skid_buffer.sv
// Two-entry buffer carrying latched read words toward the processor.
// Assumes one clock; the sink may stall, ready falls when both slots fill.
`timescale 1ns/1ps
module pmds_skid_buffer
    import pmds_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    pmds_word_if.sink        in_port,
    output logic [DATA_W-1:0] out_data,
    output logic             out_valid,
    input  wire logic        out_ready
);
    logic [DATA_W-1:0] slot [2];
    logic [1:0]        count;
    logic              rd_ptr;
    logic              wr_ptr;
    logic              push;
    logic              pop;

    assign in_port.ready = (count != 2'h2);
    assign push          = in_port.valid && in_port.ready;
    assign pop           = out_valid && out_ready;
    assign out_valid     = (count != 2'h0);
    assign out_data      = slot[rd_ptr];

    always_ff @(posedge clk) begin
        if (push) begin
            slot[wr_ptr] <= in_port.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count  <= 2'h0;
            rd_ptr <= 1'b0;
            wr_ptr <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            count <= count + {1'b0, push} - {1'b0, pop};
        end
    end
endmodule

// File: pmds_sequencer.sv
// Page mode DRAM sequencer: RAS/CAS, acknowledge and read strobe timing.
// Assumes processor strobes are synchronous to CLK_SYS and held per access.
// Functional notes
// - Single read completes in five clocks
// - Block refill: words two clocks apart, eleven
// - Row strobe stays asserted after writes
// - Initial write takes four clocks
// - Open-page write takes three clocks
// - Leaving row-held, except for a page write or an outside-space access, precharges two clocks first
// - Write start: busy and row together
// - Ack next edge, column on fourth
// - Write end drops busy, keeps row
// - Row-held: same-page write pages unless refresh pending, other DRAM accesses and refresh precharge
// - Outside-space access drops rows, goes idle
// - Page write: busy+ack first, column third
// - Page write returns to row-held state
// - Non-near write: drop row, shift two
// - Read: busy+row, column/strobe/ack two later
// - Read ends after ack and strobe
// - Latch enable holds read data one clock
// - Busy blocks any other state, refresh included
// - Address bits 21:20 choose the bank
// - Address presented one clock before strobe
`timescale 1ns/1ps
module pmds_sequencer
    import pmds_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              RESET,
    input  wire logic              READ_REQ,
    input  wire logic              WRITE_REQ,
    input  wire logic              BURST_REQ,
    input  wire logic              SAME_PAGE_WRITE,
    input  wire logic              REFRESH_PENDING,
    input  wire logic [ADDR_W-1:0] ADDR,
    input  wire logic [DATA_W-1:0] DRAM_DATA,
    output logic [BANKS-1:0]       ROW_STROBE_N,
    output logic [BANKS-1:0]       COL_STROBE_N,
    output logic [MUX_W-1:0]       DRAM_ADDR,
    output logic                   CYCLE_BUSY_FLAG,
    output logic                   PAGE_OPEN_FLAG,
    output logic                   MEM_ACK,
    output logic                   READ_DATA_STROBE_OUT,
    output logic                   DATA_LATCH_ENABLE,
    output logic [DATA_W-1:0]      READ_DATA,
    output logic                   READ_DATA_VALID,
    input  wire logic              READ_DATA_READY,
    output logic                   LATCH_STALL
);
    pmds_state_type    state;
    pmds_state_type    next_state;
    pmds_pend_type     pend;
    logic [3:0]        cnt;
    logic [1:0]        bank;
    logic              ras;
    logic              cas;
    logic              col_sel;
    logic              dram_req;
    logic              out_space;
    logic [DATA_W-1:0] latch_data;
    logic              latch_valid;
    pmds_word_if       word ();

    function automatic logic [BANKS-1:0] bank_decode(input logic [1:0] b);
        logic [BANKS-1:0] onehot;
        onehot    = '0;
        onehot[b] = 1'b1;
        return onehot;
    endfunction

    assign dram_req  = (READ_REQ || WRITE_REQ) && !ADDR[SPACE_BIT];
    assign out_space = (READ_REQ || WRITE_REQ) && ADDR[SPACE_BIT];

    // Next state; busy states never yield to refresh
    always_comb begin
        next_state = state;
        unique case (state)
            PMDS_IDLE: begin
                if (dram_req && WRITE_REQ) begin
                    next_state = PMDS_WRITE;
                end else if (dram_req && BURST_REQ) begin
                    next_state = PMDS_BLOCK;
                end else if (dram_req) begin
                    next_state = PMDS_READ;
                end
            end
            PMDS_ROW_HELD: begin
                if (out_space) begin
                    next_state = PMDS_IDLE;
                end else if (dram_req && WRITE_REQ && SAME_PAGE_WRITE
                             && !REFRESH_PENDING) begin
                    next_state = PMDS_PAGE_WRITE;
                end else if (dram_req || REFRESH_PENDING) begin
                    next_state = PMDS_PRECHARGE;
                end
            end
            PMDS_PRECHARGE: begin
                if (cnt == PRE_END_CNT) begin
                    if (!CYCLE_BUSY_FLAG) begin
                        next_state = PMDS_IDLE;
                    end else if (pend == PMDS_PEND_WRITE) begin
                        next_state = PMDS_WRITE;
                    end else if (pend == PMDS_PEND_BLOCK) begin
                        next_state = PMDS_BLOCK;
                    end else begin
                        next_state = PMDS_READ;
                    end
                end
            end
            PMDS_WRITE: begin
                if (cnt == WR_CAS_CNT) begin
                    next_state = PMDS_ROW_HELD;
                end
            end
            PMDS_PAGE_WRITE: begin
                if (cnt == PG_CAS_CNT) begin
                    next_state = PMDS_ROW_HELD;
                end
            end
            PMDS_READ: begin
                if (cnt == READ_END_CNT) begin
                    next_state = PMDS_IDLE;
                end
            end
            PMDS_BLOCK: begin
                if (cnt == BLK_END_CNT) begin
                    next_state = PMDS_IDLE;
                end
            end
            default: next_state = PMDS_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            state <= PMDS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Step counter restarts on every state change
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cnt <= CNT_ZERO;
        end else if (next_state != state) begin
            cnt <= CNT_ZERO;
        end else if (state != PMDS_IDLE && state != PMDS_ROW_HELD) begin
            cnt <= cnt + CNT_ONE;
        end
    end

    // Pending access kind and bank, captured when an access is taken
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pend <= PMDS_PEND_READ;
            bank <= 2'h0;
        end else if ((state == PMDS_IDLE || state == PMDS_ROW_HELD)
                     && dram_req) begin
            bank <= ADDR[BANK_HI:BANK_LO];
            if (WRITE_REQ) begin
                pend <= PMDS_PEND_WRITE;
            end else if (BURST_REQ) begin
                pend <= PMDS_PEND_BLOCK;
            end else begin
                pend <= PMDS_PEND_READ;
            end
        end
    end

    // Busy flag: set on access taken, cleared when the access ends
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            CYCLE_BUSY_FLAG <= 1'b0;
        end else if ((state == PMDS_IDLE || state == PMDS_ROW_HELD)
                     && dram_req && next_state != PMDS_IDLE) begin
            CYCLE_BUSY_FLAG <= 1'b1;
        end else if (next_state == PMDS_ROW_HELD
                     || next_state == PMDS_IDLE) begin
            CYCLE_BUSY_FLAG <= 1'b0;
        end
    end

    // Page open flag follows a held row and any delayed access
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            PAGE_OPEN_FLAG <= 1'b0;
        end else if (next_state == PMDS_ROW_HELD) begin
            PAGE_OPEN_FLAG <= 1'b1;
        end else if (next_state == PMDS_IDLE) begin
            PAGE_OPEN_FLAG <= 1'b0;
        end
    end

    // Row strobe: on in access and row-held, off in precharge and idle
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            ras <= 1'b0;
        end else begin
            ras <= (next_state == PMDS_WRITE || next_state == PMDS_READ
                    || next_state == PMDS_BLOCK
                    || next_state == PMDS_PAGE_WRITE
                    || next_state == PMDS_ROW_HELD);
        end
    end

    // Column strobe, acknowledge and read strobe timing
    // Write acknowledge comes early; the processor holds its data
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            cas                  <= 1'b0;
            MEM_ACK              <= 1'b0;
            READ_DATA_STROBE_OUT <= 1'b0;
        end else begin
            cas                  <= 1'b0;
            MEM_ACK              <= 1'b0;
            READ_DATA_STROBE_OUT <= 1'b0;
            unique case (state)
                PMDS_ROW_HELD: begin
                    MEM_ACK <= (next_state == PMDS_PAGE_WRITE);
                end
                PMDS_WRITE: begin
                    MEM_ACK <= (cnt == CNT_ZERO);
                    cas     <= (cnt == WR_CAS_CNT);
                end
                PMDS_PAGE_WRITE: begin
                    cas <= (cnt == PG_CAS_CNT);
                end
                PMDS_READ: begin
                    if (cnt == CNT_ONE) begin
                        cas                  <= 1'b1;
                        MEM_ACK              <= 1'b1;
                        READ_DATA_STROBE_OUT <= 1'b1;
                    end
                end
                PMDS_BLOCK: begin
                    if (cnt[0] && cnt < BLK_END_CNT) begin
                        cas                  <= 1'b1;
                        READ_DATA_STROBE_OUT <= 1'b1;
                    end
                    MEM_ACK <= (cnt == BLK_ACK_CNT);
                end
                default: begin
                    cas <= 1'b0;
                end
            endcase
        end
    end

    // Latch enable follows column strobe on reads and holds one clock
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            DATA_LATCH_ENABLE <= 1'b0;
            latch_data        <= '0;
            latch_valid       <= 1'b0;
        end else begin
            DATA_LATCH_ENABLE <= cas && READ_DATA_STROBE_OUT;
            latch_valid       <= 1'b0;
            if (cas && READ_DATA_STROBE_OUT) begin
                latch_data  <= DRAM_DATA;
                latch_valid <= 1'b1;
            end
        end
    end

    // Multiplexed address: row part before row strobe, column before cas
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            col_sel <= 1'b0;
        end else begin
            col_sel <= ras;
        end
    end

    // Row bits flow through while idle, ahead of the row strobe
    assign DRAM_ADDR = col_sel ? ADDR[MUX_W-1:0]
                               : ADDR[ROW_LO+MUX_W-1:ROW_LO];

    assign ROW_STROBE_N = ~(bank_decode(bank) & {BANKS{ras}});
    assign COL_STROBE_N = ~(bank_decode(bank) & {BANKS{cas}});

    assign word.data  = latch_data;
    assign word.valid = latch_valid;
    assign LATCH_STALL = !word.ready;

    pmds_skid_buffer u_buffer (
        .clk       (CLK_SYS),
        .reset     (RESET),
        .in_port   (word),
        .out_data  (READ_DATA),
        .out_valid (READ_DATA_VALID),
        .out_ready (READ_DATA_READY)
    );
endmodule

// File: pmds_sequencer_assertions.sv
// Checker for the page mode DRAM sequencer, bound to its top ports.
// Assumes requests are held until the access ends, as the bench does.
`timescale 1ns/1ps
module pmds_sequencer_assertions
    import pmds_pkg::*;
(
    input wire logic              CLK_SYS,
    input wire logic              RESET,
    input wire logic              READ_REQ,
    input wire logic              WRITE_REQ,
    input wire logic              BURST_REQ,
    input wire logic              SAME_PAGE_WRITE,
    input wire logic              REFRESH_PENDING,
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [BANKS-1:0]  ROW_STROBE_N,
    input wire logic [BANKS-1:0]  COL_STROBE_N,
    input wire logic [MUX_W-1:0]  DRAM_ADDR,
    input wire logic              CYCLE_BUSY_FLAG,
    input wire logic              PAGE_OPEN_FLAG,
    input wire logic              MEM_ACK,
    input wire logic              READ_DATA_STROBE_OUT,
    input wire logic              DATA_LATCH_ENABLE
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    logic idle_q;
    logic held_q;
    logic row_on;
    logic col_on;
    logic dram;
    assign row_on = !(&ROW_STROBE_N);
    assign col_on = !(&COL_STROBE_N);
    assign idle_q = !row_on && !CYCLE_BUSY_FLAG && !PAGE_OPEN_FLAG;
    assign held_q = row_on && !CYCLE_BUSY_FLAG && PAGE_OPEN_FLAG;
    assign dram = !ADDR[SPACE_BIT];
    sequence rd_seq;
        CYCLE_BUSY_FLAG && row_on ##2
        MEM_ACK && READ_DATA_STROBE_OUT && col_on ##2
        !CYCLE_BUSY_FLAG && !row_on && !PAGE_OPEN_FLAG;
    endsequence
    sequence wr_end;
        col_on && !CYCLE_BUSY_FLAG && row_on && PAGE_OPEN_FLAG;
    endsequence
    sequence wr_seq;
        CYCLE_BUSY_FLAG && row_on && !MEM_ACK ##1 MEM_ACK ##2 wr_end;
    endsequence
    sequence pre_seq;
        (!row_on && PAGE_OPEN_FLAG) [*2];
    endsequence
    sequence blk_seq;
        CYCLE_BUSY_FLAG ##2 READ_DATA_STROBE_OUT && !MEM_ACK
        ##2 READ_DATA_STROBE_OUT ##2 READ_DATA_STROBE_OUT && MEM_ACK
        ##2 READ_DATA_STROBE_OUT ##2 !CYCLE_BUSY_FLAG;
    endsequence
    AST_READ: assert property (
        READ_REQ && !BURST_REQ && dram && idle_q |=> rd_seq)
        else $error("single read timing wrong");
    AST_BLOCK: assert property (
        READ_REQ && BURST_REQ && dram && idle_q |=> blk_seq)
        else $error("block refill timing wrong");
    AST_WRITE: assert property (
        WRITE_REQ && dram && idle_q |=> wr_seq)
        else $error("single write timing wrong");
    AST_PAGE: assert property (
        WRITE_REQ && SAME_PAGE_WRITE && dram && held_q
        |=> CYCLE_BUSY_FLAG && MEM_ACK ##2 wr_end)
        else $error("page write timing wrong");
    AST_DELAYED_WRITE: assert property (
        WRITE_REQ && !SAME_PAGE_WRITE && dram && held_q
        |=> pre_seq ##1 wr_seq)
        else $error("delayed write timing wrong");
    AST_DELAYED_READ: assert property (
        READ_REQ && !BURST_REQ && dram && held_q |=> pre_seq ##1 rd_seq)
        else $error("delayed read timing wrong");
    AST_OUTSIDE: assert property (
        (READ_REQ || WRITE_REQ) && !dram && held_q |=> idle_q)
        else $error("outside access kept rows");
    AST_REFRESH: assert property (
        REFRESH_PENDING && !READ_REQ && !WRITE_REQ && held_q |=> !row_on)
        else $error("pending refresh kept rows");
    AST_BANK: assert property (
        (READ_REQ || WRITE_REQ) && dram && idle_q
        |=> ROW_STROBE_N == ~(4'h1 << ADDR[BANK_HI:BANK_LO]))
        else $error("wrong bank row strobe");
    AST_LATCH: assert property (
        $rose(READ_DATA_STROBE_OUT) |=> DATA_LATCH_ENABLE ##1
        !DATA_LATCH_ENABLE)
        else $error("latch enable misplaced");
    AST_ROW_ADDR: assert property (
        $rose(row_on) |-> $past(DRAM_ADDR)
        == $past(ADDR[ROW_LO+MUX_W-1:ROW_LO]))
        else $error("row address not set ahead of row strobe");
    AST_COL_ADDR: assert property (
        $rose(col_on) |-> $past(DRAM_ADDR) == $past(ADDR[MUX_W-1:0]))
        else $error("column address not set ahead of column strobe");
    AST_RESET: assert property (disable iff (1'b0)
        RESET |=> idle_q && !col_on && !MEM_ACK && !READ_DATA_STROBE_OUT)
        else $error("reset state wrong");
endmodule

// File: pmds_cpu_model.sv
// Processor bus model: one access at a time, takes read words.
// Assumes the bench calls access from its own process.
`timescale 1ns/1ps
module pmds_cpu_model
    import pmds_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         busy,
    input  wire logic         stall,
    output logic              read_req,
    output logic              write_req,
    output logic              burst_req,
    output logic              same_page_write,
    output logic [ADDR_W-1:0] addr,
    output logic              ready
);
    logic [ADDR_W-1:ROW_LO] last_page;
    initial begin
        {read_req, write_req, burst_req, same_page_write} = 4'h0;
        addr = 24'h0;
        last_page = {(ADDR_W-ROW_LO){1'b1}};
    end
    assign ready = !stall;
    task automatic access(input logic rd, input logic blk,
                          input logic [ADDR_W-1:0] a, output int n);
        logic seen;
        seen = 1'b0;
        @(posedge clk);
        #1;
        addr = a;
        read_req = rd;
        write_req = !rd;
        burst_req = blk;
        same_page_write = !rd && a[ADDR_W-1:ROW_LO] == last_page;
        if (!rd) last_page = a[ADDR_W-1:ROW_LO];
        for (n = 1; n < 40; n++) begin
            @(posedge clk);
            #1;
            if (busy) seen = 1'b1;
            else if (seen || (a[SPACE_BIT] && n == 2)) break;
        end
        {read_req, write_req, burst_req, same_page_write} = 4'h0;
        addr = ~a;
    endtask
endmodule

// File: test_page_mode_dram_sequencer.sv
// Self-checking bench for the page mode DRAM sequencer.
// Assumes the processor model and checker are compiled before it.
`timescale 1ns/1ps
module test_page_mode_dram_sequencer;
    import pmds_pkg::*;
    logic              clk_sys, reset, rd, wr, bst, same, refresh, stall;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dram_data, read_data;
    logic [BANKS-1:0]  row_n, col_n;
    logic              busy, page_open, ack, rds, dle, valid, ready, full;
    logic [DATA_W-1:0] exp_q[$];
    int                n_fail, compares, n, i;
    localparam logic [ADDR_W-1:0] A = 24'h100400;
    pmds_sequencer u_dut (.CLK_SYS(clk_sys), .RESET(reset),
        .READ_REQ(rd), .WRITE_REQ(wr), .BURST_REQ(bst),
        .SAME_PAGE_WRITE(same), .REFRESH_PENDING(refresh), .ADDR(addr),
        .DRAM_DATA(dram_data), .ROW_STROBE_N(row_n), .COL_STROBE_N(col_n),
        .DRAM_ADDR(), .CYCLE_BUSY_FLAG(busy), .PAGE_OPEN_FLAG(page_open),
        .MEM_ACK(ack), .READ_DATA_STROBE_OUT(rds),
        .DATA_LATCH_ENABLE(dle), .READ_DATA(read_data),
        .READ_DATA_VALID(valid), .READ_DATA_READY(ready),
        .LATCH_STALL(full));
    pmds_cpu_model u_cpu (.clk(clk_sys), .busy(busy), .stall(stall),
        .read_req(rd), .write_req(wr), .burst_req(bst),
        .same_page_write(same), .addr(addr), .ready(ready));
    always #5 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic go(input logic r, input logic b, input logic [23:0] a);
        u_cpu.access(r, b, a, n);
        if (n >= 40) begin
            n_fail++;
            test_done();
        end
    endtask
    always @(posedge clk_sys) begin
        if (valid === 1'b1 && ready === 1'b1) begin
            check(read_data, exp_q.pop_front());
        end
    end
    always @(posedge clk_sys) begin
        if (dle === 1'b1) begin
            exp_q.push_back(dram_data);
            #1 dram_data = dram_data + 32'h01010101;
        end
    end
    task automatic sc_read;
        for (i = 0; i < BANKS; i++) begin
            go(1'b1, 1'b0, {2'h0, i[1:0], 20'h00400});
            check(n, 5);
        end
    endtask
    task automatic sc_block;
        stall = 1'b1;
        fork
            go(1'b1, 1'b1, A);
            begin
                for (i = 0; i < 20 && full !== 1'b1; i++) begin
                    @(posedge clk_sys);
                    #1;
                end
                check(full, 1'b1);
                stall = 1'b0;
            end
        join
        check(n, 11);
        repeat (4) @(posedge clk_sys);
        #1;
        check(exp_q.size(), 0);
        check(valid, 1'b0);
    endtask
    task automatic sc_write;
        go(1'b0, 1'b0, A);
        check(n, 4);
        check({page_open, row_n}, 5'h1d);
        go(1'b0, 1'b0, A + 24'h4);
        check(n, 3);
        check({page_open, row_n}, 5'h1d);
        go(1'b0, 1'b0, A + 24'h800);
        check(n, 6);
        go(1'b1, 1'b0, A);
        check(n, 7);
        check(page_open, 1'b0);
    endtask
    task automatic sc_outside;
        go(1'b0, 1'b0, A);
        go(1'b1, 1'b1, A);
        check(n, 13);
        go(1'b0, 1'b0, A);
        go(1'b0, 1'b0, A | 24'h400000);
        check({page_open, row_n}, 5'h0f);
        go(1'b0, 1'b0, A);
        check(n, 4);
    endtask
    task automatic sc_refresh;
        refresh = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        check(row_n, 4'hf);
        refresh = 1'b0;
    endtask
    task automatic sc_reset;
        reset = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        check({row_n, col_n, busy, page_open, ack, rds}, 12'hff0);
    endtask
    initial begin
        clk_sys = 1'b0;
        reset = 1'b1;
        refresh = 1'b0;
        stall = 1'b0;
        dram_data = 32'h11223344;
        n_fail = 0;
        compares = 0;
        repeat (5) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        check({row_n, col_n, busy, page_open, ack, rds}, 12'hff0);
        sc_read();
        sc_block();
        sc_write();
        sc_outside();
        sc_refresh();
        sc_reset();
        go(1'b0, 1'b0, A);
        sc_reset();
        test_done();
    end
endmodule
bind pmds_sequencer pmds_sequencer_assertions u_chk (.CLK_SYS, .RESET,
    .READ_REQ, .WRITE_REQ, .BURST_REQ, .SAME_PAGE_WRITE, .REFRESH_PENDING,
    .ADDR, .ROW_STROBE_N, .COL_STROBE_N, .DRAM_ADDR, .CYCLE_BUSY_FLAG,
    .PAGE_OPEN_FLAG,
    .MEM_ACK, .READ_DATA_STROBE_OUT, .DATA_LATCH_ENABLE);
